//--- rtl/psic_pkg.sv
// Purpose: shared constants and types for the processor state interrupt control
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes: register map is a plain address/strobe port
package psic_pkg;

    // ------------------------------------------------------------
    // processor states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PSIC_ST_1 = 4'h1,
        PSIC_ST_2 = 4'h2,
        PSIC_ST_3 = 4'h4,
        PSIC_ST_4 = 4'h8
    } psic_state_t;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC = 32;
    localparam int NUM_STATES = 4;
    localparam int NUM_GR = 16;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATE = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PC = 8'h0C;
    localparam logic [7:0] ADDR_FLAG = 8'h10;
    localparam logic [7:0] ADDR_SW_STATE = 8'h14;
    localparam logic [7:0] ADDR_EVT = 8'h18;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h1C;
    localparam logic [7:0] ADDR_CONSOLE = 8'h20;
    localparam logic [7:0] ADDR_GR_BASE = 8'h40;
    localparam logic [7:0] ADDR_GR_LAST = 8'h7C;

    // ------------------------------------------------------------
    // console register select codes
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_SCRATCH_ADDR = 3'h0;
    localparam logic [2:0] SEL_MAIN_ADDR = 3'h1;
    localparam logic [2:0] SEL_MAIN_DATA = 3'h2;
    localparam logic [2:0] SEL_UTILITY = 3'h3;
    localparam logic [2:0] SEL_INTERMEDIATE = 3'h4;
    localparam logic [2:0] SEL_OPCODE = 3'h5;
    localparam logic [2:0] SEL_STATUS = 3'h6;

    // ------------------------------------------------------------
    // source classes: bits 0,1 go to machine-condition state
    // ------------------------------------------------------------
    localparam logic [31:0] MACHINE_SRC_MASK = 32'h0000_0003;
    localparam logic [31:0] UNMASKABLE_SRC = 32'h0000_0003;
    localparam int CONSOLE_REQ_BIT = 17;
    localparam int MACHINE_CHECK_BIT = 1;

    // ------------------------------------------------------------
    // reset values and event bits
    // ------------------------------------------------------------
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam int EVT_SWITCH = 0;
    localparam int EVT_STOP = 1;
    localparam int EVT_CONSOLE = 2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PSIC_COMPLETE = 2'h0,
        PSIC_SUPPRESS = 2'h1,
        PSIC_TERMINATE = 2'h2
    } psic_action_t;

    typedef struct packed {
        logic sample;
        logic start_device_busy;
        logic [31:0] pc;
        logic [1:0] fault_kind;
    } psic_boundary_t;

    typedef struct packed {
        logic mem_protect;
        logic main_store;
        logic data_reg;
    } psic_parity_t;

    typedef struct packed {
        logic set_pulse;
        logic [2:0] select;
        logic [31:0] data;
    } psic_console_t;

    typedef struct packed {
        logic [6:0] scratch_addr;
        logic [18:0] main_addr;
        logic [31:0] main_data;
        logic [31:0] indicator;
        logic [7:0] opcode;
        logic [3:0] first_reg;
        logic [3:0] second_reg;
        logic staticize;
    } psic_datapath_t;

endpackage

//--- rtl/psic_prio.sv
// Purpose: fixed-order priority encoder for interrupt requests
// Assumes: bit 0 is highest priority
// Notes: purely combinational
`timescale 1ns/1ps
module psic_prio (
    // requests
    input wire logic [31:0] i_req,
    // result
    output logic o_any,
    output logic [4:0] o_idx
);
    always_comb begin
        o_any = 1'b0;
        o_idx = 5'h00;
        for (int i = psic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (i_req[i]) begin
                o_any = 1'b1;
                o_idx = 5'(i);
            end
        end
    end
endmodule

//--- rtl/psic_top.sv
// Purpose: processor state switching, per-state masks, console register path
// Assumes: datapath presents an instruction boundary pulse with its outcome
// Notes: on a taken interrupt the state switches in one cycle
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module psic_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // interrupt sources, from pins
    input wire logic [31:0] i_src,
    // datapath
    input wire psic_pkg::psic_boundary_t i_bnd,
    input wire psic_pkg::psic_parity_t i_par,
    input wire psic_pkg::psic_datapath_t i_dp,
    // console
    input wire psic_pkg::psic_console_t i_con,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // processor outputs
    output logic [3:0] o_state,
    output logic o_switch,
    output logic [31:0] o_resume_pc,
    output psic_pkg::psic_action_t o_action,
    output logic o_stop,
    output logic [31:0] o_display,
    output logic [31:0] o_utility,
    output logic [31:0] o_intermediate,
    output logic o_irq
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    psic_pkg::psic_state_t state_reg;
    logic [7:0] pre_level_field;
    logic [31:0] interrupt_mask [4];
    logic [31:0] interrupt_status [4];
    logic [31:0] pc_reg [4];
    logic [31:0] gr_reg [4][16];
    logic [31:0] flag_reg;
    logic [31:0] src_meta_reg;
    logic [31:0] src_sync_reg;
    logic [31:0] pending_reg;
    logic [31:0] utility_reg;
    logic [31:0] intermediate_reg;
    logic [2:0] evt_reg;
    logic [2:0] evt_mask_reg;
    logic [31:0] opcode_display_reg;
    logic [3:0] first_operand_reg_select;
    logic [3:0] second_operand_reg_select;
    logic stop_reg;

    function automatic logic [1:0] st_idx(input psic_pkg::psic_state_t s);
        case (s)
            psic_pkg::PSIC_ST_1: st_idx = 2'h0;
            psic_pkg::PSIC_ST_2: st_idx = 2'h1;
            psic_pkg::PSIC_ST_3: st_idx = 2'h2;
            default: st_idx = 2'h3;
        endcase
    endfunction

    logic [1:0] cur;
    assign cur = st_idx(state_reg);

    // ------------------------------------------------------------
    // request synchronisation and pending
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            src_meta_reg <= 32'h0000_0000;
            src_sync_reg <= 32'h0000_0000;
        end else begin
            src_meta_reg <= i_src;
            src_sync_reg <= src_meta_reg;
        end
    end

    logic [31:0] eligible;
    logic any_req;
    logic [4:0] win_idx;
    logic take;
    logic to_machine;
    logic par_irq;
    logic par_stop;

    // machine check raised by main-store or data-register parity outside state 4, stop inside it; protect errors always stop
    assign par_irq = (i_par.main_store | i_par.data_reg) & (state_reg != psic_pkg::PSIC_ST_4);
    assign par_stop = i_par.mem_protect
        | ((i_par.main_store | i_par.data_reg) & (state_reg == psic_pkg::PSIC_ST_4));

    always_comb begin
        eligible = pending_reg & (interrupt_mask[cur] | psic_pkg::UNMASKABLE_SRC);
        if (i_bnd.start_device_busy) begin
            eligible[psic_pkg::CONSOLE_REQ_BIT] = 1'b0;
        end
        // a handler state is not re-entered by its own class
        if (state_reg == psic_pkg::PSIC_ST_4) begin
            eligible = 32'h0000_0000;
        end else if (state_reg == psic_pkg::PSIC_ST_3) begin
            eligible = eligible & psic_pkg::MACHINE_SRC_MASK;
        end
    end

    psic_prio u_prio (
        .i_req(eligible),
        .o_any(any_req),
        .o_idx(win_idx)
    );

    assign take = i_bnd.sample & any_req & ~stop_reg;
    assign to_machine = psic_pkg::MACHINE_SRC_MASK[win_idx];

    // pending latches every source; only the served one clears
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pending_reg <= 32'h0000_0000;
        end else begin
            logic [31:0] nxt;
            nxt = pending_reg;
            if (take) begin
                nxt[win_idx] = 1'b0;
            end
            nxt = nxt | src_sync_reg;
            nxt[psic_pkg::MACHINE_CHECK_BIT] = nxt[psic_pkg::MACHINE_CHECK_BIT] | par_irq;
            pending_reg <= nxt;
        end
    end

    // ------------------------------------------------------------
    // state switch
    // ------------------------------------------------------------
    logic sw_wr;
    assign sw_wr = i_wr & (i_addr == psic_pkg::ADDR_SW_STATE);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= psic_pkg::PSIC_ST_1;
            pre_level_field <= 8'h00;
        end else if (take) begin
            pre_level_field <= {4'h0, state_reg};
            state_reg <= to_machine ? psic_pkg::PSIC_ST_4 : psic_pkg::PSIC_ST_3;
        end else if (sw_wr) begin
            // executive software moves to any state, e.g. into state 2
            case (i_wdata[1:0])
                2'h0: state_reg <= psic_pkg::PSIC_ST_1;
                2'h1: state_reg <= psic_pkg::PSIC_ST_2;
                2'h2: state_reg <= psic_pkg::PSIC_ST_3;
                default: state_reg <= psic_pkg::PSIC_ST_4;
            endcase
            pre_level_field <= {4'h0, state_reg};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_switch <= 1'b0;
            o_action <= psic_pkg::PSIC_COMPLETE;
            o_resume_pc <= psic_pkg::PC_RESET;
        end else begin
            o_switch <= take;
            if (take) begin
                o_action <= psic_pkg::psic_action_t'(i_bnd.fault_kind);
                o_resume_pc <= pc_reg[to_machine ? 2'h3 : 2'h2];
            end
        end
    end

    // ------------------------------------------------------------
    // per-state scratch pad and shared flag register
    // ------------------------------------------------------------
    logic [3:0] gr_idx;
    assign gr_idx = i_addr[5:2];

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int s = 0; s < psic_pkg::NUM_STATES; s++) begin
                interrupt_mask[s] <= psic_pkg::MASK_RESET;
                interrupt_status[s] <= 32'h0000_0000;
                pc_reg[s] <= psic_pkg::PC_RESET;
            end
            flag_reg <= 32'h0000_0000;
        end else begin
            if (i_wr) begin
                case (i_addr)
                    psic_pkg::ADDR_MASK: interrupt_mask[cur] <= i_wdata;
                    psic_pkg::ADDR_STATUS: interrupt_status[cur] <= i_wdata;
                    psic_pkg::ADDR_PC: pc_reg[cur] <= i_wdata;
                    psic_pkg::ADDR_FLAG: flag_reg <= i_wdata;
                    default: ;
                endcase
            end
            // hardware sets land over a same-cycle software write
            if (take) begin
                pc_reg[cur] <= i_bnd.pc;
                interrupt_status[to_machine ? 2'h3 : 2'h2][win_idx] <= 1'b1;
                flag_reg[win_idx] <= 1'b1;
            end
        end
    end

    // general registers: one bank per state, no reset
    always_ff @(posedge i_clk) begin
        if (i_wr && i_addr >= psic_pkg::ADDR_GR_BASE && i_addr <= psic_pkg::ADDR_GR_LAST) begin
            gr_reg[cur][gr_idx] <= i_wdata;
        end
    end

    // ------------------------------------------------------------
    // console set and display
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            utility_reg <= 32'h0000_0000;
            intermediate_reg <= 32'h0000_0000;
            opcode_display_reg <= 32'h0000_0000;
        end else begin
            if (i_con.set_pulse) begin
                case (i_con.select)
                    // whole word replaced, unlit bits are lost
                    psic_pkg::SEL_UTILITY: utility_reg <= i_dp.indicator;
                    psic_pkg::SEL_INTERMEDIATE: intermediate_reg <= i_con.data;
                    psic_pkg::SEL_OPCODE: opcode_display_reg <= i_con.data;
                    default: ;
                endcase
            end else if (i_dp.staticize) begin
                opcode_display_reg[15:0] <= {i_dp.opcode,
                    i_dp.first_reg, i_dp.second_reg};
            end
        end
    end

    always_comb begin
        first_operand_reg_select = opcode_display_reg[7:4];
        second_operand_reg_select = opcode_display_reg[3:0];
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_display <= 32'h0000_0000;
        end else begin
            case (i_con.select)
                psic_pkg::SEL_SCRATCH_ADDR: o_display <= {25'h0, i_dp.scratch_addr};
                psic_pkg::SEL_MAIN_ADDR: o_display <= {13'h0, i_dp.main_addr};
                psic_pkg::SEL_MAIN_DATA: o_display <= i_dp.main_data;
                psic_pkg::SEL_UTILITY: o_display <= utility_reg;
                psic_pkg::SEL_INTERMEDIATE: o_display <= intermediate_reg;
                psic_pkg::SEL_OPCODE: o_display <= {opcode_display_reg[31:8],
                    first_operand_reg_select, second_operand_reg_select};
                psic_pkg::SEL_STATUS: o_display <= {16'h0000, pre_level_field,
                    4'h0, state_reg};
                default: o_display <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // stop, events, interrupt line
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            stop_reg <= 1'b0;
        end else if (par_stop) begin
            stop_reg <= 1'b1;
        end
    end

    logic [2:0] evt_set;
    assign evt_set = {i_con.set_pulse, par_stop, take};

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            evt_reg <= 3'h0;
            evt_mask_reg <= 3'h0;
        end else begin
            // set wins over a simultaneous clear
            if (i_wr && i_addr == psic_pkg::ADDR_EVT) begin
                evt_reg <= (evt_reg & ~i_wdata[2:0]) | evt_set;
            end else begin
                evt_reg <= evt_reg | evt_set;
            end
            if (i_wr && i_addr == psic_pkg::ADDR_EVT_MASK) begin
                evt_mask_reg <= i_wdata[2:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_irq <= 1'b0;
            o_stop <= 1'b0;
            o_state <= 4'h1;
            o_utility <= 32'h0000_0000;
            o_intermediate <= 32'h0000_0000;
        end else begin
            o_irq <= |(evt_reg & evt_mask_reg);
            o_stop <= stop_reg;
            o_state <= state_reg;
            o_utility <= utility_reg;
            o_intermediate <= intermediate_reg;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            if (i_addr >= psic_pkg::ADDR_GR_BASE && i_addr <= psic_pkg::ADDR_GR_LAST) begin
                o_rdata <= gr_reg[cur][gr_idx];
            end else begin
                case (i_addr)
                    psic_pkg::ADDR_STATE: o_rdata <= {28'h0000000, state_reg};
                    psic_pkg::ADDR_MASK: o_rdata <= interrupt_mask[cur];
                    psic_pkg::ADDR_STATUS: o_rdata <= interrupt_status[cur];
                    psic_pkg::ADDR_PC: o_rdata <= pc_reg[cur];
                    psic_pkg::ADDR_FLAG: o_rdata <= flag_reg;
                    psic_pkg::ADDR_SW_STATE: o_rdata <= {30'h0, cur};
                    psic_pkg::ADDR_EVT: o_rdata <= {29'h0, evt_reg};
                    psic_pkg::ADDR_EVT_MASK: o_rdata <= {29'h0, evt_mask_reg};
                    psic_pkg::ADDR_CONSOLE: o_rdata <= {16'h0000, pre_level_field,
                        3'h0, stop_reg, pending_reg[3:0]};
                    default: o_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

//--- tb/psic_dp_model.sv
// Purpose: datapath stand-in giving boundaries, pc and display values
// Assumes: one instruction boundary every four cycles
// Notes: pc steps by four at each boundary
`timescale 1ns/1ps
module psic_dp_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // bench control
    input wire logic i_busy,
    input wire logic [1:0] i_kind,
    input wire logic i_stat,
    // to design
    output psic_pkg::psic_boundary_t o_bnd,
    output psic_pkg::psic_datapath_t o_dp
);
    logic [1:0] cnt_reg;
    logic [31:0] pc_reg;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_reg <= 2'h0;
            pc_reg <= 32'h0000_1000;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == 2'h3) begin
                pc_reg <= pc_reg + 32'h0000_0004;
            end
        end
    end

    always_comb begin
        o_bnd = '{cnt_reg == 2'h3, i_busy, pc_reg, i_kind};
        o_dp = '{7'h2A, 19'h5_1234, 32'hCAFE_0001, 32'h0F0F_00A5, 8'h9C, 4'h3, 4'hB, i_stat};
    end
endmodule

//--- tb/psic_top_props.sv
// Purpose: concurrent checks on the psic_top ports
// Assumes: registered outputs as handed over
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module psic_top_props (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // watched inputs
    input wire psic_pkg::psic_boundary_t i_bnd,
    input wire psic_pkg::psic_parity_t i_par,
    input wire psic_pkg::psic_datapath_t i_dp,
    input wire psic_pkg::psic_console_t i_con,
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    // watched outputs
    input wire logic [31:0] o_rdata,
    input wire logic [3:0] o_state,
    input wire logic o_switch,
    input wire psic_pkg::psic_action_t o_action,
    input wire logic o_stop,
    input wire logic [31:0] o_utility
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    // ------------------------------------------------
    // sequences and assertions
    // ------------------------------------------------
    sequence s_util_set;
        i_con.set_pulse && i_con.select == psic_pkg::SEL_UTILITY;
    endsequence
    sequence s_protect_err;
        i_par.mem_protect;
    endsequence

    // o_state shows the state of the take cycle alongside o_switch, the new one after
    a_one_state: assert property ($onehot(o_state))
        else $error("state not one-hot");
    a_enter_3_or_4: assert property (o_switch |=> o_state inside {4'h4, 4'h8})
        else $error("switch into wrong state");
    a_none_in_4: assert property (o_switch |-> o_state != 4'h8)
        else $error("interrupt taken in state 4");
    a_state3_machine: assert property (o_switch && o_state == 4'h4 |=> o_state == 4'h8)
        else $error("state 3 left to wrong state");
    a_take_at_bnd: assert property (o_switch |-> $past(i_bnd.sample))
        else $error("switch without boundary");
    a_action_echo: assert property (o_switch |-> o_action == $past(i_bnd.fault_kind))
        else $error("wrong action for instruction");
    a_stop_blocks: assert property (o_stop |-> ##2 !o_switch)
        else $error("switch while stopped");
    a_stop_sticky: assert property (o_stop |=> o_stop)
        else $error("stop dropped");
    a_protect_stop: assert property (s_protect_err |-> ##[1:4] o_stop)
        else $error("no stop on protect error");
    a_unmapped_rd: assert property ($past(i_rd) && $past(i_addr) == 8'h24 |-> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_util_load: assert property (s_util_set |-> ##2 o_utility == $past(i_dp.indicator, 2))
        else $error("utility not loaded from indicators");
endmodule

bind psic_top psic_top_props psic_top_props_i (
    .i_clk(i_clk), .i_srst(i_srst), .i_bnd(i_bnd), .i_par(i_par), .i_dp(i_dp),
    .i_con(i_con), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .o_state(o_state),
    .o_switch(o_switch), .o_action(o_action), .o_stop(o_stop), .o_utility(o_utility)
);

//--- tb/tb_psic_top.sv
// Purpose: self-checking bench for psic_top
// Assumes: datapath model gives a boundary every four cycles
// Notes: outputs sampled 1 ns after the edge to let updates land
`timescale 1ns/1ps
module tb_psic_top;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [31:0] i_src = 32'h0;
    psic_pkg::psic_boundary_t bnd;
    psic_pkg::psic_datapath_t dp;
    psic_pkg::psic_parity_t i_par = '0;
    psic_pkg::psic_console_t i_con = '0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic busy = 1'b0;
    logic stat = 1'b0;
    logic [1:0] kind = 2'h1;
    logic [31:0] o_rdata, o_resume_pc, o_display, o_utility, o_intermediate, pc_exp;
    logic [3:0] o_state;
    logic o_switch, o_stop, o_irq;
    psic_pkg::psic_action_t o_action;
    logic [31:0] disp_exp [3] = '{32'h0000_002A, 32'h0005_1234, 32'hCAFE_0001};
    bit seen;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;

    initial forever #4 i_clk = ~i_clk;

    psic_dp_model psic_dp_model_i (
        .i_clk(i_clk), .i_srst(i_srst), .i_busy(busy), .i_kind(kind), .i_stat(stat),
        .o_bnd(bnd), .o_dp(dp)
    );
    psic_top psic_top_i (
        .i_clk(i_clk), .i_srst(i_srst), .i_src(i_src), .i_bnd(bnd), .i_par(i_par),
        .i_dp(dp), .i_con(i_con), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_state(o_state), .o_switch(o_switch),
        .o_resume_pc(o_resume_pc), .o_action(o_action), .o_stop(o_stop),
        .o_display(o_display), .o_utility(o_utility), .o_intermediate(o_intermediate),
        .o_irq(o_irq)
    );

    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic give_verdict();
        $display("Checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // one-cycle strobes; a gap cycle keeps each assignment in its own step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(nm, e, o_rdata);
    endtask

    task automatic wait_sw(input int lim);
        seen = 1'b0;
        repeat (lim) begin
            if (!seen) begin
                @(posedge i_clk);
                #1 seen = (o_switch === 1'b1);
            end
        end
        if (seen) begin
            pc_exp = bnd.pc - 32'h0000_0004;
        end
    endtask

    task automatic take(input string nm, input logic [3:0] st);
        wait_sw(24);
        chk(nm, 32'h1, 32'(seen));
        // the state port lags the switch pulse by a cycle
        tick(1);
        chk(nm, 32'(st), 32'(o_state));
    endtask

    // one-edge source pulse, so a served request does not pend again
    task automatic pulse(input logic [31:0] v);
        i_src <= v;
        @(posedge i_clk);
        i_src <= 32'h0;
    endtask

    task automatic con_set(input logic [2:0] sel, input logic [31:0] d);
        i_con <= '{1'b1, sel, d};
        tick(1);
        i_con.set_pulse <= 1'b0;
        tick(2);
    endtask

    task automatic reset_dut();
        i_srst <= 1'b1;
        tick(12);
        i_srst <= 1'b0;
    endtask

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        reset_dut();
        chk("state", 32'(psic_pkg::PSIC_ST_1), 32'(o_state));
        rdc("mask", psic_pkg::ADDR_MASK, psic_pkg::MASK_RESET);
        wr(8'h24, 32'hFFFF_FFFF);
        rdc("unmapped", 8'h24, 32'h0);
        wr(psic_pkg::ADDR_EVT_MASK, 32'h1);
        pulse(32'h0000_0020);
        wait_sw(24);
        chk("masked", 32'h0, 32'(seen));
        wr(psic_pkg::ADDR_MASK, 32'h0000_0020);
        take("take", psic_pkg::PSIC_ST_3);
        chk("action", 32'(psic_pkg::PSIC_SUPPRESS), 32'(o_action));
        chk("resume", psic_pkg::PC_RESET, o_resume_pc);
        tick(2);
        chk("irq", 32'h1, 32'(o_irq));
        rdc("status", psic_pkg::ADDR_STATUS, 32'h0000_0020);
        wr(psic_pkg::ADDR_PC, 32'h0000_0300);
        wr(psic_pkg::ADDR_EVT, 32'h1);
        wr(psic_pkg::ADDR_EVT_MASK, 32'h0);
        tick(3);
        chk("irq_clr", 32'h0, 32'(o_irq));
        wr(psic_pkg::ADDR_SW_STATE, 32'h0);
        rdc("saved_pc", psic_pkg::ADDR_PC, pc_exp);
        wr(psic_pkg::ADDR_SW_STATE, 32'h1);
        tick(3);
        chk("state2", 32'(psic_pkg::PSIC_ST_2), 32'(o_state));
        wr(psic_pkg::ADDR_SW_STATE, 32'h0);
        wr(psic_pkg::ADDR_MASK, 32'h0000_0048);
        pulse(32'h0000_0048);
        take("prio", psic_pkg::PSIC_ST_3);
        chk("resume3", 32'h0000_0300, o_resume_pc);
        rdc("first", psic_pkg::ADDR_STATUS, 32'h0000_0028);
        wr(psic_pkg::ADDR_SW_STATE, 32'h0);
        take("second", psic_pkg::PSIC_ST_3);
        rdc("next", psic_pkg::ADDR_STATUS, 32'h0000_0068);
        wr(psic_pkg::ADDR_SW_STATE, 32'h0);
        wr(psic_pkg::ADDR_MASK, 32'h0002_0000);
        busy <= 1'b1;
        pulse(32'h0002_0000);
        wait_sw(24);
        chk("deferred", 32'h0, 32'(seen));
        busy <= 1'b0;
        take("console", psic_pkg::PSIC_ST_3);
        kind <= 2'h2;
        pulse(32'h0000_0002);
        take("machine", psic_pkg::PSIC_ST_4);
        chk("action2", 32'(psic_pkg::PSIC_TERMINATE), 32'(o_action));
        i_par.main_store <= 1'b1;
        tick(1);
        i_par.main_store <= 1'b0;
        tick(4);
        chk("stop4", 32'h1, 32'(o_stop));
        reset_dut();
        i_par.data_reg <= 1'b1;
        tick(1);
        i_par.data_reg <= 1'b0;
        take("parity", psic_pkg::PSIC_ST_4);
        chk("nostop", 32'h0, 32'(o_stop));
        i_con.select <= psic_pkg::SEL_STATUS;
        tick(2);
        chk("levels", 32'h0000_0108, o_display);
        reset_dut();
        i_par.mem_protect <= 1'b1;
        tick(1);
        i_par.mem_protect <= 1'b0;
        tick(4);
        chk("protect", 32'h1, 32'(o_stop));
        con_set(psic_pkg::SEL_UTILITY, 32'h1234_5678);
        chk("utility", 32'h0F0F_00A5, o_utility);
        con_set(psic_pkg::SEL_INTERMEDIATE, 32'h1234_5678);
        chk("intermediate", 32'h1234_5678, o_intermediate);
        for (int s = 0; s < 3; s++) begin
            con_set(3'(s), 32'hFFFF_FFFF);
            chk("display", disp_exp[s], o_display);
        end
        stat <= 1'b1;
        tick(1);
        stat <= 1'b0;
        i_con.select <= psic_pkg::SEL_OPCODE;
        tick(3);
        chk("opcode", 32'h0000_9C3B, o_display & 32'h0000_FFFF);
        give_verdict();
    end
endmodule
